// File: logic/voltage_restraint_overcurrent.sv
// Purpose: phase overcurrent element with voltage restraint, APB registers
// Assumes: measurements synchronous to pclk, single clock domain
// Notes:   zero wait state APB slave, definite delay on a 1 ms tick
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module voltage_restraint_overcurrent #(
  parameter int TICK_CYCLES = vro_pkg::TICK_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire vro_pkg::phase_meas_t meas [3],
  input  wire logic                 vts_mcb_trip,
  input  wire logic                 ext_block1_in,
  input  wire logic                 ext_block2_in,
  input  wire logic                 ext_trip_cmd_block_in,
  input  wire logic                 rev_interlock_in,
  input  wire logic [3:0]           adapt_set_in,
  output logic                      element_active,
  output logic                      external_block_flag,
  output logic                      reverse_interlock_flag,
  output logic                      trip_command_blocked,
  output logic                      external_trip_command_block,
  output logic                      phase1_alarm_flag,
  output logic                      phase2_alarm_flag,
  output logic                      phase3_alarm_flag,
  output logic                      alarm_flag,
  output logic                      phase1_trip_flag,
  output logic                      phase2_trip_flag,
  output logic                      phase3_trip_flag,
  output logic                      trip_flag,
  output logic                      trip_command_out,
  output logic [2:0]                selected_adaptive_set,
  output logic                      base_set_active,
  output logic                      adaptive_set1_active,
  output logic                      adaptive_set2_active,
  output logic                      adaptive_set3_active,
  output logic                      adaptive_set4_active,
  output logic                      irq
);
  // settings registers
  logic [8:0]  ctrl_q;
  logic [15:0] pickup_q;
  logic [15:0] minpick_q;
  logic [15:0] vtsec_q;
  logic [15:0] delay_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_en_q;
  logic [33:0] alarm_event_count_q;
  logic [33:0] trip_command_count_q;

  // apb decode
  wire         wr_setup = psel && !penable && pwrite;
  wire         rd_setup = psel && !penable && !pwrite;
  wire         wr_en    = psel && penable && pwrite;
  wire  [31:0] wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire  [31:0] wbits    = pwdata & wmask;
  wire         wr_ctrl  = wr_en && paddr == vro_pkg::CTRL_OFS;
  wire         wr_pick  = wr_en && paddr == vro_pkg::PICKUP_OFS;
  wire         wr_minp  = wr_en && paddr == vro_pkg::MINPICK_OFS;
  wire         wr_vts   = wr_en && paddr == vro_pkg::VTSEC_OFS;
  wire         wr_dly   = wr_en && paddr == vro_pkg::DELAY_OFS;
  wire         wr_iclr  = wr_en && paddr == vro_pkg::IRQ_CLR_OFS;
  wire         wr_ien   = wr_en && paddr == vro_pkg::IRQ_EN_OFS;
  wire         wr_cmd   = wr_en && paddr == vro_pkg::CMD_OFS;
  wire         mapped   = paddr[1:0] == 2'b00 && paddr <= vro_pkg::TRP_HI_OFS;

  // active parameter set, lowest adaptive input wins
  wire  [2:0]  set_d    = adapt_set_in[0] ? 3'h1 : adapt_set_in[1] ? 3'h2 :
                          adapt_set_in[2] ? 3'h3 : adapt_set_in[3] ? 3'h4 : 3'h0;
  // restraint enable of the selected set
  wire         restrain = ctrl_q[vro_pkg::CTRL_RST_LSB + 32'(set_d)];

  // field phase-phase wiring overrides neutral selection
  wire         use_pn   = ctrl_q[vro_pkg::CTRL_PN_SEL] && !ctrl_q[vro_pkg::CTRL_FIELD_PP];
  wire  [31:0] pn_prod  = vtsec_q * vro_pkg::INV_SQRT3_Q16;
  wire  [15:0] nominal_voltage_ref = use_pn ? pn_prod[31:16] : vtsec_q;

  // blocking terms
  wire         enabled  = ctrl_q[vro_pkg::CTRL_ENABLE];
  wire         ext_blk  = ext_block1_in || ext_block2_in;
  // supervision trip blocks the restrained element
  wire         vts_blk  = ctrl_q[vro_pkg::CTRL_VTS_EN] && vts_mcb_trip && restrain;
  wire         blocked  = !enabled || ext_blk || rev_interlock_in || vts_blk;

  vro_pkg::restraint_cfg_t cfg;
  assign cfg.restrain   = restrain;
  assign cfg.pickup     = pickup_q;
  assign cfg.min_pickup = minpick_q;
  assign cfg.vmax       = nominal_voltage_ref;

  // per-phase pickup and definite delay
  logic [2:0]  over;
  logic [2:0]  alarm_d;
  logic [2:0]  trip_d;
  logic [2:0]  alarm_q;
  logic [2:0]  trip_q;
  logic [15:0] dly_cnt_q [3];
  logic [16:0] tick_cnt_q;
  wire         tick = tick_cnt_q == 17'(TICK_CYCLES - 1);

  // delay tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)  tick_cnt_q <= 17'h0_0000;
    else if (tick) tick_cnt_q <= 17'h0_0000;
    else           tick_cnt_q <= tick_cnt_q + 17'h0_0001;
  end

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      wire [15:0] v_sel = use_pn ? meas[ph].v_pn : meas[ph].v_pp;
      restraint_pickup u_pick (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (cfg),
        .current (meas[ph].current),
        .voltage (v_sel),
        .over_q  (over[ph])
      );
      assign alarm_d[ph] = over[ph] && !blocked;
      assign trip_d[ph]  = alarm_d[ph] && dly_cnt_q[ph] >= delay_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                              dly_cnt_q[ph] <= 16'h0000;
        else if (!alarm_d[ph])                     dly_cnt_q[ph] <= 16'h0000;
        else if (tick && dly_cnt_q[ph] < delay_q)  dly_cnt_q[ph] <= dly_cnt_q[ph] + 16'h0001;
      end
    end
  endgenerate

  wire         alarm_any = |alarm_d;
  wire         trip_any  = |trip_d;
  // trip command only when not blocked
  wire         cmd_d     = trip_any && !ext_trip_cmd_block_in;
  wire         alarm_ev  = alarm_any && !alarm_flag;
  wire         trip_ev   = cmd_d && !trip_command_out;
  logic        vts_blk_q;
  wire         vts_ev    = vts_blk && !vts_blk_q;

  wire         clr_alm   = wr_cmd && wbits[0];
  wire         clr_trp   = wr_cmd && wbits[1];
  wire  [33:0] alm_d     = clr_alm ? 34'h0_0000_0000 :
                           (alarm_ev && alarm_event_count_q != vro_pkg::CNT_MAX) ?
                           alarm_event_count_q + 34'h0_0000_0001 : alarm_event_count_q;
  wire  [33:0] trp_d     = clr_trp ? 34'h0_0000_0000 :
                           (trip_ev && trip_command_count_q != vro_pkg::CNT_MAX) ?
                           trip_command_count_q + 34'h0_0000_0001 : trip_command_count_q;

  // sticky interrupt status, set wins over clear
  wire  [2:0]  irq_set   = {vts_ev, trip_ev, alarm_ev};
  wire  [2:0]  irq_d     = (irq_stat_q & ~(wr_iclr ? wbits[2:0] : 3'h0)) | irq_set;

  // status word
  wire  [31:0] status_w  = {14'h0000, set_d, vts_blk, blocked, trip_command_out,
                            trip_flag, trip_q, alarm_flag, alarm_q, enabled,
                            3'h0};

  // read mux
  wire  [31:0] rd_d =
    paddr == vro_pkg::CTRL_OFS     ? {23'h00_0000, ctrl_q} :
    paddr == vro_pkg::PICKUP_OFS   ? {16'h0000, pickup_q} :
    paddr == vro_pkg::MINPICK_OFS  ? {16'h0000, minpick_q} :
    paddr == vro_pkg::VTSEC_OFS    ? {16'h0000, vtsec_q} :
    paddr == vro_pkg::DELAY_OFS    ? {16'h0000, delay_q} :
    paddr == vro_pkg::STATUS_OFS   ? status_w :
    paddr == vro_pkg::IRQ_STAT_OFS ? {29'h0000_0000, irq_stat_q} :
    paddr == vro_pkg::IRQ_EN_OFS   ? {29'h0000_0000, irq_en_q} :
    paddr == vro_pkg::ALM_LO_OFS   ? alarm_event_count_q[31:0] :
    paddr == vro_pkg::ALM_HI_OFS   ? {30'h0000_0000, alarm_event_count_q[33:32]} :
    paddr == vro_pkg::TRP_LO_OFS   ? trip_command_count_q[31:0] :
    paddr == vro_pkg::TRP_HI_OFS   ? {30'h0000_0000, trip_command_count_q[33:32]} :
                                     32'h0000_0000;

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      if (rd_setup) prdata <= mapped ? rd_d : 32'h0000_0000;
      if (rd_setup || wr_setup) pslverr <= !mapped;
    end
  end

  // settings writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= vro_pkg::CTRL_RST;
      pickup_q  <= vro_pkg::PICKUP_RST;
      minpick_q <= vro_pkg::MINPICK_RST;
      vtsec_q   <= vro_pkg::VTSEC_RST;
      delay_q   <= vro_pkg::DELAY_RST;
      irq_en_q  <= 3'h0;
    end else begin
      if (wr_ctrl) ctrl_q    <= (ctrl_q & ~wmask[8:0]) | wbits[8:0];
      if (wr_pick) pickup_q  <= (pickup_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_minp) minpick_q <= (minpick_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_vts)  vtsec_q   <= (vtsec_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_dly)  delay_q   <= (delay_q & ~wmask[15:0]) | wbits[15:0];
      if (wr_ien)  irq_en_q  <= (irq_en_q & ~wmask[2:0]) | wbits[2:0];
    end
  end

  // counters and interrupt state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_event_count_q  <= 34'h0_0000_0000;
      trip_command_count_q <= 34'h0_0000_0000;
      irq_stat_q           <= 3'h0;
      irq                  <= 1'b0;
      vts_blk_q            <= 1'b0;
    end else begin
      alarm_event_count_q  <= alm_d;
      trip_command_count_q <= trp_d;
      irq_stat_q           <= irq_d;
      irq                  <= |(irq_d & irq_en_q);
      vts_blk_q            <= vts_blk;
    end
  end

  // one-hot set indications, each from a flop of its own
  wire  [4:0]  set_flag_d = 5'h01 << set_d;
  logic [4:0]  set_flag_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q                     <= 3'h0;
      trip_q                      <= 3'h0;
      alarm_flag                  <= 1'b0;
      trip_flag                   <= 1'b0;
      trip_command_out            <= 1'b0;
      element_active              <= 1'b0;
      external_block_flag         <= 1'b0;
      reverse_interlock_flag      <= 1'b0;
      trip_command_blocked        <= 1'b0;
      external_trip_command_block <= 1'b0;
      selected_adaptive_set       <= 3'h0;
      set_flag_q                  <= 5'h01;
    end else begin
      alarm_q                     <= alarm_d;
      trip_q                      <= trip_d;
      alarm_flag                  <= alarm_any;
      trip_flag                   <= trip_any;
      trip_command_out            <= cmd_d;
      element_active              <= enabled;
      external_block_flag         <= ext_blk;
      reverse_interlock_flag      <= rev_interlock_in;
      trip_command_blocked        <= trip_any && ext_trip_cmd_block_in;
      external_trip_command_block <= ext_trip_cmd_block_in;
      selected_adaptive_set       <= set_d;
      set_flag_q                  <= set_flag_d;
    end
  end

  // per-phase and set indication wiring
  assign phase1_alarm_flag    = alarm_q[0];
  assign phase2_alarm_flag    = alarm_q[1];
  assign phase3_alarm_flag    = alarm_q[2];
  assign phase1_trip_flag     = trip_q[0];
  assign phase2_trip_flag     = trip_q[1];
  assign phase3_trip_flag     = trip_q[2];
  assign base_set_active      = set_flag_q[0];
  assign adaptive_set1_active = set_flag_q[1];
  assign adaptive_set2_active = set_flag_q[2];
  assign adaptive_set3_active = set_flag_q[3];
  assign adaptive_set4_active = set_flag_q[4];

  a_alarm_count: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_ev && !clr_alm && alarm_event_count_q != vro_pkg::CNT_MAX
    |=> alarm_event_count_q == $past(alarm_event_count_q) + 34'h0_0000_0001)
    else $error("alarm count did not advance");
  a_trip_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(trip_command_out) && !$past(clr_trp)
    |-> trip_command_count_q == $past(trip_command_count_q) + 34'h0_0000_0001
        || $past(trip_command_count_q) == vro_pkg::CNT_MAX)
    else $error("trip count did not advance");
  a_count_sat: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_event_count_q == vro_pkg::CNT_MAX && !clr_alm |=> alarm_event_count_q == vro_pkg::CNT_MAX)
    else $error("alarm count wrapped");
  a_count_clr: assert property (@(posedge pclk) disable iff (!presetn)
    clr_trp |=> trip_command_count_q == 34'h0_0000_0000)
    else $error("trip count not cleared");
  a_vts_block: assert property (@(posedge pclk) disable iff (!presetn)
    vts_blk |=> !alarm_flag && !trip_command_out)
    else $error("supervision block ignored");
  a_cmd_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    ext_trip_cmd_block_in |=> !trip_command_out && (trip_command_blocked == trip_flag))
    else $error("trip command not blocked");
  a_gen_trip: assert property (@(posedge pclk) disable iff (!presetn)
    trip_flag == (phase1_trip_flag || phase2_trip_flag || phase3_trip_flag))
    else $error("general trip mismatch");
  a_set_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    adapt_set_in[0] |=> adaptive_set1_active && !base_set_active)
    else $error("adaptive set one not shown");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(irq_d) & $past(irq_en_q)))
    else $error("interrupt level mismatch");

  // bus answer, blocking, flag and counter guards
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> pready)
    else $error("access without ready");
  a_rd_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_block_clear: assert property (@(posedge pclk) disable iff (!presetn)
    blocked |=> !alarm_flag && !trip_flag && !trip_command_out)
    else $error("blocked element still picked up");
  a_ext_flag: assert property (@(posedge pclk) disable iff (!presetn)
    ext_block1_in || ext_block2_in |=> external_block_flag)
    else $error("external block flag missing");
  a_rev_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rev_interlock_in |=> reverse_interlock_flag)
    else $error("interlock flag missing");
  a_trip_alarm: assert property (@(posedge pclk) disable iff (!presetn)
    trip_flag |-> alarm_flag)
    else $error("trip without alarm");
  a_cmd_trip: assert property (@(posedge pclk) disable iff (!presetn)
    trip_command_out |-> trip_flag)
    else $error("trip command without trip");
  a_active_flag: assert property (@(posedge pclk) disable iff (!presetn)
    !enabled |=> !element_active && !alarm_flag)
    else $error("disabled element active");
  a_trip_delay: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_d[0] && dly_cnt_q[0] < delay_q |=> !phase1_trip_flag)
    else $error("trip before delay");
  a_trip_sat: assert property (@(posedge pclk) disable iff (!presetn)
    trip_command_count_q == vro_pkg::CNT_MAX && !clr_trp
    |=> trip_command_count_q == vro_pkg::CNT_MAX)
    else $error("trip count wrapped");
endmodule : voltage_restraint_overcurrent
`default_nettype wire

// File: logic/vro_pkg.sv
// Purpose: constants and types for the voltage restraint overcurrent element
// Assumes: 100 MHz pclk, APB register access, 16-bit measured magnitudes
// Notes:   all register offsets are byte addresses on a 32-bit APB bus
package vro_pkg;

  localparam int MEAS_W = 16;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] PICKUP_OFS    = 8'h04;
  localparam logic [7:0] MINPICK_OFS   = 8'h08;
  localparam logic [7:0] VTSEC_OFS     = 8'h0C;
  localparam logic [7:0] DELAY_OFS     = 8'h10;
  localparam logic [7:0] STATUS_OFS    = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS   = 8'h1C;
  localparam logic [7:0] IRQ_EN_OFS    = 8'h20;
  localparam logic [7:0] CMD_OFS       = 8'h24;
  localparam logic [7:0] ALM_LO_OFS    = 8'h28;
  localparam logic [7:0] ALM_HI_OFS    = 8'h2C;
  localparam logic [7:0] TRP_LO_OFS    = 8'h30;
  localparam logic [7:0] TRP_HI_OFS    = 8'h34;

  // control field positions
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_VTS_EN   = 1;
  localparam int CTRL_PN_SEL   = 2;  // measuring channel: 1 = phase to neutral
  localparam int CTRL_FIELD_PP = 3;  // field VT wired phase to phase
  localparam int CTRL_RST_LSB  = 4;  // five restraint enables, base set first
  localparam int CTRL_W        = 9;

  // reset values
  localparam logic [8:0]  CTRL_RST    = 9'h001;
  localparam logic [15:0] PICKUP_RST  = 16'h1000;
  localparam logic [15:0] MINPICK_RST = 16'h0100;
  localparam logic [15:0] VTSEC_RST   = 16'h1000;
  localparam logic [15:0] DELAY_RST   = 16'h0000;

  // counters span ten decimal digits
  localparam int          CNT_W   = 34;
  localparam logic [33:0] CNT_MAX = 34'h2_540B_E3FF;  // 9999999999

  // one over root three, Q16
  localparam logic [15:0] INV_SQRT3_Q16 = 16'h93CD;

  // delay time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;

  // interrupt bit positions
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_TRIP  = 1;
  localparam int IRQ_VTS   = 2;
  localparam int IRQ_W     = 3;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] v_pp;
    logic [15:0] v_pn;
  } phase_meas_t;

  typedef struct packed {
    logic        restrain;
    logic [15:0] pickup;
    logic [15:0] min_pickup;
    logic [15:0] vmax;
  } restraint_cfg_t;

endpackage : vro_pkg

// File: logic/restraint_pickup.sv
// Purpose: one phase pickup decision with voltage restraint
// Assumes: magnitudes in common units, vmax the nominal reference
// Notes:   threshold compared by cross multiplication, no divider
`timescale 1ns/1ps
`default_nettype none
module restraint_pickup (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire vro_pkg::restraint_cfg_t cfg,
  input  wire logic [15:0]             current,
  input  wire logic [15:0]             voltage,
  output logic                         over_q
);
  logic [15:0] vmin;
  logic [31:0] i_times_vmax;
  logic [31:0] pick_times_v;
  logic [17:0] i_times_4;
  logic        low_band;
  logic        high_band;
  logic        thr_ok;
  logic        min_ok;
  logic        over_d;

  assign vmin         = {2'b00, cfg.vmax[15:2]};
  assign low_band     = voltage <= vmin;
  assign high_band    = voltage >= cfg.vmax;
  assign i_times_vmax = current * cfg.vmax;
  assign pick_times_v = cfg.pickup * voltage;
  assign i_times_4    = {current, 2'b00};
  assign thr_ok = high_band ? (current >= cfg.pickup) :
                  low_band  ? (i_times_4 >= {2'b00, cfg.pickup}) :
                              (i_times_vmax >= pick_times_v);
  assign min_ok = current >= cfg.min_pickup;
  assign over_d = cfg.restrain ? (thr_ok && min_ok) : (current >= cfg.pickup);

  // registered decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) over_q <= 1'b0;
    else          over_q <= over_d;
  end

  a_plain_pickup: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg.restrain && current >= cfg.pickup |=> over_q)
    else $error("unrestrained pickup missed");
  a_min_clamp: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.restrain && current < cfg.min_pickup |=> !over_q)
    else $error("pickup below minimum setting");
  a_low_band: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.restrain && low_band && !high_band && min_ok && i_times_4 < {2'b00, cfg.pickup}
    |=> !over_q)
    else $error("pickup below quarter threshold");
endmodule : restraint_pickup
`default_nettype wire

// File: bench/meas_source.sv
// Purpose: instrument transformer model feeding the element
// Assumes: fault current on phase one only, balanced voltages
// Notes:   phase-ground level modelled as half the phase-phase level
`timescale 1ns/1ps
`default_nettype none
module meas_source (
  input  wire logic [15:0]          cur,
  input  wire logic [15:0]          volt,
  output var  vro_pkg::phase_meas_t meas [3]
);
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      meas[p].current = (p == 0) ? cur : 16'h0000;
      meas[p].v_pp    = volt;
      meas[p].v_pn    = {1'b0, volt[15:1]};
    end
  end
endmodule : meas_source
`default_nettype wire

// File: bench/test_voltage_restraint_overcurrent.sv
// Purpose: register and pickup checks of the restraint element
// Assumes: zero wait APB slave, delay zero except in its own scenario
// Notes:   short tick count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module test_voltage_restraint_overcurrent;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                 vts = 1'b0, ext_blk = 1'b0, tcb = 1'b0, rev = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, rdata;
  logic [15:0]          cur = 16'h0000, volt = 16'h0000;
  logic [3:0]           adapt = 4'h0, as;
  logic [2:0]           sel;
  logic                 pready, pslverr, last_err, irq, act, xbf, rvf, tcbd, tcbf;
  logic                 al1, al2, al3, alarm, tr1, tr2, tr3, trip, tcmd, base;
  vro_pkg::phase_meas_t meas [3];
  logic [31:0]          rst_val [4] = '{32'(vro_pkg::CTRL_RST), 32'(vro_pkg::PICKUP_RST),
                                        32'(vro_pkg::MINPICK_RST), 32'(vro_pkg::VTSEC_RST)};
  int                   errors = 0, check_count = 0;

  meas_source i_meas_source (.cur(cur), .volt(volt), .meas(meas));

  voltage_restraint_overcurrent #(.TICK_CYCLES(10)) i_voltage_restraint_overcurrent (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .meas(meas), .vts_mcb_trip(vts), .ext_block1_in(ext_blk),
    .ext_block2_in(ext_blk), .ext_trip_cmd_block_in(tcb), .rev_interlock_in(rev),
    .adapt_set_in(adapt), .element_active(act), .external_block_flag(xbf),
    .reverse_interlock_flag(rvf), .trip_command_blocked(tcbd),
    .external_trip_command_block(tcbf), .phase1_alarm_flag(al1), .phase2_alarm_flag(al2),
    .phase3_alarm_flag(al3), .alarm_flag(alarm), .phase1_trip_flag(tr1),
    .phase2_trip_flag(tr2), .phase3_trip_flag(tr3), .trip_flag(trip),
    .trip_command_out(tcmd), .selected_adaptive_set(sel), .base_set_active(base),
    .adaptive_set1_active(as[0]), .adaptive_set2_active(as[1]),
    .adaptive_set3_active(as[2]), .adaptive_set4_active(as[3]), .irq(irq));

  // free running clock
  always #5 pclk = ~pclk;

  task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  // one APB transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // apply phase one current and voltage, then look at the alarm
  task automatic probe(input logic [15:0] c, input logic [15:0] v, input logic e);
    cur <= c;
    volt <= v;
    repeat (3) @(posedge pclk);
    chk("alarm", alarm, e);
  endtask : probe

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(8'(4 * i), 1'b0, 32'h0);
      chk("reset value", rdata, rst_val[i]);
    end
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped", last_err, 1);
    probe(16'h0FFF, 16'h0000, 1'b0);
    probe(16'h1000, 16'h0000, 1'b1);
    chk("flags", {al1,al2,al3,tr1,tr2,tr3,trip,tcmd,act}, 9'b100100111);
    apb(vro_pkg::CTRL_OFS, 1'b1, 32'h011);
    probe(16'h03FF, 16'h0400, 1'b0);
    probe(16'h0400, 16'h0400, 1'b1);
    probe(16'h07FF, 16'h0800, 1'b0);
    probe(16'h0800, 16'h0800, 1'b1);
    probe(16'h0FFF, 16'h1000, 1'b0);
    probe(16'h1000, 16'h1388, 1'b1);
    apb(vro_pkg::PICKUP_OFS, 1'b1, 32'h200);
    probe(16'h00FF, 16'h0000, 1'b0);
    probe(16'h0100, 16'h0000, 1'b1);
    apb(vro_pkg::PICKUP_OFS, 1'b1, 32'h1000);
    for (int k = 0; k < 5; k++) begin
      adapt <= (k == 0) ? 4'h0 : 4'(1 << (k - 1));
      repeat (3) @(posedge pclk);
      chk("set", {sel, base, as}, {3'(k), k == 0, (k == 0) ? 4'h0 : 4'(1 << (k - 1))});
    end
    adapt <= 4'h1;
    probe(16'h0400, 16'h0400, 1'b0);
    adapt <= 4'h0;
    probe(16'h0400, 16'h0400, 1'b1);
    apb(vro_pkg::CTRL_OFS, 1'b1, 32'h013);
    vts <= 1'b1;
    probe(16'h0400, 16'h0400, 1'b0);
    vts <= 1'b0;
    probe(16'h0400, 16'h0400, 1'b1);
    apb(vro_pkg::CTRL_OFS, 1'b1, 32'h011);
    probe(16'h0708, 16'h0800, 1'b0);
    apb(vro_pkg::CTRL_OFS, 1'b1, 32'h015);
    probe(16'h0708, 16'h0800, 1'b1);
    apb(vro_pkg::CTRL_OFS, 1'b1, 32'h01D);
    probe(16'h0708, 16'h0800, 1'b0);
    tcb <= 1'b1;
    probe(16'h1000, 16'h1388, 1'b1);
    chk("trip cmd", {tcmd, tcbd, tcbf}, 3'b011);
    ext_blk <= 1'b1;
    rev <= 1'b1;
    probe(16'h1000, 16'h1388, 1'b0);
    chk("block flags", {xbf, rvf}, 2'b11);
    probe(16'h0000, 16'h0000, 1'b0);
    tcb <= 1'b0;
    ext_blk <= 1'b0;
    rev <= 1'b0;
    apb(vro_pkg::ALM_LO_OFS, 1'b0, 32'h0);
    chk("alarm count", rdata, 9);
    apb(vro_pkg::TRP_LO_OFS, 1'b0, 32'h0);
    chk("trip count", rdata, 8);
    apb(vro_pkg::CMD_OFS, 1'b1, 32'h3);
    apb(vro_pkg::ALM_LO_OFS, 1'b0, 32'h0);
    chk("alarm count clr", rdata, 0);
    apb(vro_pkg::TRP_LO_OFS, 1'b0, 32'h0);
    chk("trip count clr", rdata, 0);
    apb(vro_pkg::IRQ_CLR_OFS, 1'b1, 32'h7);
    apb(vro_pkg::IRQ_EN_OFS, 1'b1, 32'h1);
    probe(16'h1000, 16'h1388, 1'b1);
    chk("irq raised", irq, 1);
    apb(vro_pkg::IRQ_EN_OFS, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", irq, 0);
    apb(vro_pkg::IRQ_STAT_OFS, 1'b0, 32'h0);
    chk("irq sticky", rdata[0], 1);
    apb(vro_pkg::IRQ_CLR_OFS, 1'b1, 32'h1);
    apb(vro_pkg::IRQ_STAT_OFS, 1'b0, 32'h0);
    chk("irq cleared", rdata[0], 0);
    apb(vro_pkg::ALM_LO_OFS, 1'b0, 32'h0);
    chk("alarm count", rdata, 1);
    // same two-tick delay at low and at full voltage
    apb(vro_pkg::DELAY_OFS, 1'b1, 32'h2);
    for (int k = 0; k < 2; k++) begin
      probe(16'h0000, 16'h0000, 1'b0);
      probe(16'h1000, (k == 0) ? 16'h0000 : 16'h1388, 1'b1);
      chk("trip early", trip, 0);
      repeat (25) @(posedge pclk);
      chk("trip delayed", trip, 1);
    end
    end_of_test();
  end
endmodule : test_voltage_restraint_overcurrent
`default_nettype wire
